// ===== logic/eeprom_slave_end.sv
// eeprom end of the two-wire link: framing, address match, acknowledge
`timescale 1ns/1ps

// Overview of operation
// - master opens each command with start, address
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - sda changes only while scl is low
// - master ends every transfer with stop
// - stop after reading enters standby
// - receiver pulls sda low on ninth clock
// - acknowledge address only on own match
// - upper four address bits must be 1010
// - two select bits match select pins
// - last address bit: one read, zero write
// - acknowledge every byte once write-addressed
// - read: send eight, sample ninth, continue
// - no master acknowledge: stop sending, await stop
// - sda pulled low or released, never high
// - write inhibit high blocks write execution
// - undriven write inhibit counts as low
// - write inhibit steady from start to stop
// - bits move on the serial clock only
// - no address acknowledge while write busy
module eeprom_slave_end (
    input wire logic i_clk,
    input wire logic i_reset_n,
    eeprom_link_if.device link,
    input wire logic i_chip_select_bit_a,
    input wire logic i_chip_select_bit_b,
    input wire logic i_write_inhibit_input,
    input wire logic i_write_inhibit_driven,
    input wire logic i_busy,
    input wire logic [7:0] i_tx_byte,
    output logic o_tx_load,
    output logic [7:0] o_rx_byte,
    output logic o_rx_valid,
    output logic o_start,
    output logic o_stop,
    output logic o_selected,
    output logic o_read_mode,
    output logic o_block_bit,
    output logic o_standby
);
    import eeprom_link_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        dev_state_t state;
        logic [3:0] cnt;
        logic [7:0] shift;
        logic rw;
        logic block;
        logic drive_low;
        logic mack;
        logic standby;
        logic read_seq;
        logic [3:0] pin_meta;
        logic [3:0] pin;
        logic [7:0] rx_byte;
        logic rx_valid;
        logic tx_load;
        logic start_p;
        logic stop_p;
    } dev_reg_t;

    dev_reg_t r;
    dev_reg_t next_r;

    logic scl_level;
    logic scl_rise;
    logic scl_fall;
    logic sda_level;
    logic sda_rise;
    logic sda_fall;
    logic start_seen;
    logic stop_seen;
    logic addr_match;
    logic writes_blocked;

    // ------------------------------------------------------------
    // line sampling
    // ------------------------------------------------------------
    // both lines pass equal delay so their relative timing holds
    line_sync scl_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_line(link.scl),
        .o_level(scl_level),
        .o_rise(scl_rise),
        .o_fall(scl_fall)
    );

    line_sync sda_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_line(link.sda),
        .o_level(sda_level),
        .o_rise(sda_rise),
        .o_fall(sda_fall)
    );

    // ------------------------------------------------------------
    // bus conditions and address decode
    // ------------------------------------------------------------
    // data edges while the clock is high are framing conditions
    assign start_seen = sda_fall & scl_level;
    assign stop_seen = sda_rise & scl_level;

    // pin bits: 0 select a, 1 select b, 2 inhibit, 3 inhibit driven
    assign addr_match = (r.shift[ADDR_TYPE_MSB:ADDR_TYPE_LSB] == SLAVE_TYPE_CODE)
        & (r.shift[ADDR_CS_A_BIT] == r.pin[0])
        & (r.shift[ADDR_CS_B_BIT] == r.pin[1]);

    // a floating inhibit pin reads as the pull-down level
    assign writes_blocked = r.pin[2] & r.pin[3];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.rx_valid = 1'b0;
        next_r.tx_load = 1'b0;
        next_r.start_p = 1'b0;
        next_r.stop_p = 1'b0;
        next_r.pin_meta = {i_write_inhibit_driven, i_write_inhibit_input,
            i_chip_select_bit_b, i_chip_select_bit_a};
        next_r.pin = r.pin_meta;
        if (start_seen) begin
            // restart address reception from any state
            next_r.state = DEV_ADDR;
            next_r.cnt = BIT_COUNT_RESET;
            next_r.drive_low = 1'b0;
            next_r.standby = 1'b0;
            next_r.read_seq = 1'b0;
            next_r.start_p = 1'b1;
        end else if (stop_seen) begin
            // stop ends whatever was in progress
            next_r.state = DEV_IDLE;
            next_r.drive_low = 1'b0;
            next_r.stop_p = 1'b1;
            next_r.standby = r.read_seq | r.standby;
            next_r.read_seq = 1'b0;
        end else begin
            unique case (r.state)
                DEV_IDLE, DEV_WAIT_STOP: begin
                    next_r.drive_low = 1'b0;
                end
                DEV_ADDR: begin
                    // shift address bits on the serial clock only
                    if (scl_rise && r.cnt != BITS_PER_BYTE) begin
                        next_r.shift = {r.shift[6:0], sda_level};
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    // decide on the falling edge ending the eighth bit
                    if (scl_fall && r.cnt == BITS_PER_BYTE) begin
                        if (addr_match && !i_busy) begin
                            next_r.state = DEV_ACK_ADDR;
                            next_r.drive_low = 1'b1;
                            next_r.rw = r.shift[ADDR_RW_BIT];
                            next_r.block = r.shift[ADDR_BLOCK_BIT];
                        end else begin
                            next_r.state = DEV_WAIT_STOP;
                        end
                    end
                end
                DEV_ACK_ADDR: begin
                    // ninth clock over: turn around or keep receiving
                    if (scl_fall) begin
                        next_r.cnt = BIT_COUNT_RESET;
                        if (r.rw == RW_READ) begin
                            next_r.state = DEV_READ_BYTE;
                            next_r.shift = i_tx_byte;
                            next_r.drive_low = ~i_tx_byte[7];
                            next_r.tx_load = 1'b1;
                            next_r.read_seq = 1'b1;
                        end else begin
                            next_r.state = DEV_WRITE_BYTE;
                            next_r.drive_low = 1'b0;
                        end
                    end
                end
                DEV_WRITE_BYTE: begin
                    if (scl_rise && r.cnt != BITS_PER_BYTE) begin
                        next_r.shift = {r.shift[6:0], sda_level};
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    // every received byte is acknowledged
                    if (scl_fall && r.cnt == BITS_PER_BYTE) begin
                        next_r.state = DEV_ACK_WRITE;
                        next_r.drive_low = 1'b1;
                        next_r.rx_byte = r.shift;
                        next_r.rx_valid = ~writes_blocked;
                    end
                end
                DEV_ACK_WRITE: begin
                    if (scl_fall) begin
                        next_r.state = DEV_WRITE_BYTE;
                        next_r.drive_low = 1'b0;
                        next_r.cnt = BIT_COUNT_RESET;
                    end
                end
                DEV_READ_BYTE: begin
                    if (scl_rise) begin
                        next_r.cnt = r.cnt + 4'h1;
                    end
                    // data moves only after the clock has fallen
                    if (scl_fall) begin
                        if (r.cnt == BITS_PER_BYTE) begin
                            next_r.state = DEV_READ_ACK;
                            next_r.drive_low = 1'b0;
                            next_r.cnt = BIT_COUNT_RESET;
                        end else begin
                            next_r.shift = {r.shift[6:0], 1'b0};
                            next_r.drive_low = ~r.shift[6];
                        end
                    end
                end
                DEV_READ_ACK: begin
                    // master answer sampled while the ninth clock is high
                    if (scl_rise) begin
                        next_r.mack = ~sda_level;
                    end
                    if (scl_fall) begin
                        if (r.mack) begin
                            next_r.state = DEV_READ_BYTE;
                            next_r.shift = i_tx_byte;
                            next_r.drive_low = ~i_tx_byte[7];
                            next_r.tx_load = 1'b1;
                        end else begin
                            next_r.state = DEV_WAIT_STOP;
                        end
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            r <= '0;
            r.state <= DEV_IDLE;
            r.standby <= STANDBY_RESET;
            r.shift <= BYTE_RESET;
            r.rx_byte <= BYTE_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // open drain: data output tied low, enable does the work
    assign link.dev_sda_out = 1'b0;
    assign link.dev_sda_oe_n = ~r.drive_low;
    assign o_tx_load = r.tx_load;
    assign o_rx_byte = r.rx_byte;
    assign o_rx_valid = r.rx_valid;
    assign o_start = r.start_p;
    assign o_stop = r.stop_p;
    assign o_selected = (r.state == DEV_ACK_WRITE) | (r.state == DEV_WRITE_BYTE)
        | (r.state == DEV_READ_BYTE) | (r.state == DEV_READ_ACK)
        | (r.state == DEV_ACK_ADDR);
    assign o_read_mode = r.read_seq;
    assign o_block_bit = r.block;
    assign o_standby = r.standby;

endmodule

// ===== logic/eeprom_link_pkg.sv
// shared constants and types for the two-wire eeprom link
package eeprom_link_pkg;

    // ------------------------------------------------------------
    // clock and serial clock timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int SCL_PERIOD_NS = 400;
    localparam int QUARTER_CYCLES = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
    localparam logic [1:0] QUARTER_LAST = 2'(QUARTER_CYCLES - 1);

    // ------------------------------------------------------------
    // byte framing
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
    localparam logic [1:0] PHASE_LAST = 2'h3;

    // ------------------------------------------------------------
    // slave address byte layout
    // ------------------------------------------------------------
    localparam int ADDR_TYPE_MSB = 7;
    localparam int ADDR_TYPE_LSB = 4;
    localparam int ADDR_CS_A_BIT = 3;
    localparam int ADDR_CS_B_BIT = 2;
    localparam int ADDR_BLOCK_BIT = 1;
    localparam int ADDR_RW_BIT = 0;
    localparam logic [3:0] SLAVE_TYPE_CODE = 4'hA;
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic LINE_IDLE = 1'b1;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic STANDBY_RESET = 1'b1;

    // ------------------------------------------------------------
    // state and command encodings
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_ADDR,
        DEV_ACK_ADDR,
        DEV_WRITE_BYTE,
        DEV_ACK_WRITE,
        DEV_READ_BYTE,
        DEV_READ_ACK,
        DEV_WAIT_STOP
    } dev_state_t;

    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_START,
        HOST_XFER,
        HOST_STOP
    } host_state_t;

    typedef enum logic [1:0] {
        CMD_START,
        CMD_WRITE,
        CMD_READ,
        CMD_STOP
    } host_cmd_t;

endpackage

// ===== logic/eeprom_link_if.sv
// two-wire link between bus master and eeprom slave
`timescale 1ns/1ps
interface eeprom_link_if;

    // ------------------------------------------------------------
    // driver signals, enables active low
    // ------------------------------------------------------------
    logic host_scl_out;
    logic host_scl_oe_n;
    logic host_sda_out;
    logic host_sda_oe_n;
    logic dev_sda_out;
    logic dev_sda_oe_n;

    // ------------------------------------------------------------
    // resolved wired-and lines with pull-ups
    // ------------------------------------------------------------
    logic scl;
    logic sda;

    // released driver leaves the line to the pull-up
    assign scl = host_scl_oe_n | host_scl_out;
    assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

    modport device (
        input scl,
        input sda,
        output dev_sda_out,
        output dev_sda_oe_n
    );

    modport host (
        input scl,
        input sda,
        output host_scl_out,
        output host_scl_oe_n,
        output host_sda_out,
        output host_sda_oe_n
    );

endinterface

// ===== logic/line_sync.sv
// two-flop synchroniser with edge detection for one line
`timescale 1ns/1ps
module line_sync (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_line,
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    import eeprom_link_pkg::*;

    typedef struct packed {
        logic meta;
        logic level;
        logic prev;
    } sync_reg_t;

    sync_reg_t r;
    sync_reg_t next_r;

    // meta feeds level only; edges compare level with its delay
    always_comb begin
        next_r = r;
        next_r.meta = i_line;
        next_r.level = r.meta;
        next_r.prev = r.level;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            r <= {LINE_IDLE, LINE_IDLE, LINE_IDLE};
        end else begin
            r <= next_r;
        end
    end

    assign o_level = r.level;
    assign o_rise = r.level & ~r.prev;
    assign o_fall = ~r.level & r.prev;

endmodule

// ===== logic/bus_master_end.sv
// bus master end of the two-wire link: clock divider and byte sequencer
`timescale 1ns/1ps
module bus_master_end (
    input wire logic i_clk,
    input wire logic i_reset_n,
    eeprom_link_if.host link,
    input wire logic i_cmd_valid,
    input wire eeprom_link_pkg::host_cmd_t i_cmd,
    input wire logic [7:0] i_wdata,
    input wire logic i_ack_send,
    output logic o_cmd_ready,
    output logic o_done,
    output logic [7:0] o_rdata,
    output logic o_ack_seen
);
    import eeprom_link_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        host_state_t state;
        logic [1:0] qcnt;
        logic [1:0] phase;
        logic [3:0] bit_idx;
        logic [7:0] shift;
        logic [7:0] rx;
        logic is_read;
        logic ack_send;
        logic scl_low;
        logic sda_low;
        logic [7:0] rdata;
        logic ack_seen;
        logic done;
    } host_reg_t;

    host_reg_t r;
    host_reg_t next_r;
    logic sda_level;
    logic tick;

    // data line read back through the synchroniser
    line_sync sda_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_line(link.sda),
        .o_level(sda_level),
        .o_rise(),
        .o_fall()
    );

    // quarter-period enable of the serial clock
    assign tick = (r.qcnt == QUARTER_LAST);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.qcnt = (tick || r.state == HOST_IDLE) ? 2'h0 : r.qcnt + 2'h1;
        unique case (r.state)
            HOST_IDLE: begin
                if (i_cmd_valid) begin
                    next_r.phase = 2'h0;
                    next_r.bit_idx = BIT_COUNT_RESET;
                    unique case (i_cmd)
                        CMD_START: begin
                            // command opens with start, address byte next
                            next_r.state = HOST_START;
                            next_r.sda_low = 1'b0;
                            next_r.scl_low = 1'b1;
                        end
                        CMD_WRITE: begin
                            next_r.state = HOST_XFER;
                            next_r.is_read = 1'b0;
                            next_r.shift = i_wdata;
                            next_r.scl_low = 1'b1;
                            next_r.sda_low = ~i_wdata[7];
                        end
                        CMD_READ: begin
                            next_r.state = HOST_XFER;
                            next_r.is_read = 1'b1;
                            next_r.ack_send = i_ack_send;
                            next_r.scl_low = 1'b1;
                            next_r.sda_low = 1'b0;
                        end
                        CMD_STOP: begin
                            next_r.state = HOST_STOP;
                            next_r.scl_low = 1'b1;
                            next_r.sda_low = 1'b1;
                        end
                    endcase
                end
            end
            HOST_START: begin
                if (tick) begin
                    next_r.phase = r.phase + 2'h1;
                    unique case (r.phase)
                        2'h0: next_r.scl_low = 1'b0;
                        2'h1: next_r.sda_low = 1'b1;
                        2'h2: next_r.scl_low = 1'b1;
                        2'h3: begin
                            next_r.state = HOST_IDLE;
                            next_r.done = 1'b1;
                        end
                    endcase
                end
            end
            HOST_STOP: begin
                if (tick) begin
                    next_r.phase = r.phase + 2'h1;
                    unique case (r.phase)
                        2'h0: next_r.scl_low = 1'b0;
                        2'h1: next_r.sda_low = 1'b0;
                        2'h2: next_r.scl_low = 1'b0;
                        2'h3: begin
                            next_r.state = HOST_IDLE;
                            next_r.done = 1'b1;
                        end
                    endcase
                end
            end
            HOST_XFER: begin
                if (tick) begin
                    next_r.phase = r.phase + 2'h1;
                    unique case (r.phase)
                        2'h0: next_r.scl_low = 1'b0;
                        2'h1: begin
                            // sample while the clock is high
                            if (r.bit_idx == BITS_PER_BYTE) begin
                                next_r.ack_seen = ~sda_level;
                            end else if (r.is_read) begin
                                next_r.rx = {r.rx[6:0], sda_level};
                            end
                        end
                        2'h2: next_r.scl_low = 1'b1;
                        2'h3: begin
                            // new data only a quarter after the clock fell
                            if (r.bit_idx == BITS_PER_BYTE) begin
                                next_r.state = HOST_IDLE;
                                next_r.done = 1'b1;
                                next_r.rdata = r.rx;
                            end else begin
                                next_r.bit_idx = r.bit_idx + 4'h1;
                                if (r.bit_idx == BITS_PER_BYTE - 4'h1) begin
                                    next_r.sda_low = r.is_read & r.ack_send;
                                end else begin
                                    next_r.sda_low = ~r.is_read & ~r.shift[6];
                                    next_r.shift = {r.shift[6:0], 1'b0};
                                end
                            end
                        end
                    endcase
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            r <= '0;
            r.state <= HOST_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign link.host_scl_out = 1'b0;
    assign link.host_scl_oe_n = ~r.scl_low;
    assign link.host_sda_out = 1'b0;
    assign link.host_sda_oe_n = ~r.sda_low;
    assign o_cmd_ready = (r.state == HOST_IDLE);
    assign o_done = r.done;
    assign o_rdata = r.rdata;
    assign o_ack_seen = r.ack_seen;

endmodule

// ===== dv/eeprom_link_props.sv
// wire-level checks of the two-wire eeprom link
`timescale 1ns/1ps
module eeprom_link_props (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe_n,
    input wire logic host_scl_out,
    input wire logic host_sda_out,
    input wire logic o_start,
    input wire logic o_stop
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    AST_DEV_OD: assert property (dev_sda_out == 1'b0)
        else $error("device drives sda high");
    AST_HOST_OD: assert property (!host_sda_out && !host_scl_out)
        else $error("master drives a line high");
    AST_DEV_HOLD: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("device moved sda while scl high");
    AST_START: assert property ($fell(sda) && scl |-> ##[2:4] o_start)
        else $error("start not reported");
    AST_STOP: assert property ($rose(sda) && scl |-> ##[2:4] o_stop)
        else $error("stop not reported");
    AST_SCL_HIGH: assert property ($rose(scl) |-> scl [*3])
        else $error("scl high phase too short");
    AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*2])
        else $error("scl low phase too short");
    AST_ACK_HOLD: assert property ($fell(dev_sda_oe_n) |-> !dev_sda_oe_n [*6])
        else $error("device pull too short");
endmodule

// ===== dv/testbench.sv
// random transfers between master end and eeprom end
`timescale 1ns/1ps
module testbench;
    import eeprom_link_pkg::*;
    logic i_clk = 0, i_reset_n = 0, i_cmd_valid = 0, i_ack_send = 0;
    logic csa = 0, csb = 0, inh = 0, drv = 0, i_busy = 0;
    host_cmd_t i_cmd = CMD_START;
    logic [7:0] i_wdata = 8'h00, i_tx_byte = 8'h5A, o_rdata, o_rx_byte, a;
    logic o_cmd_ready, o_done, o_ack_seen, o_tx_load, o_rx_valid, o_start, o_stop, o_standby;
    logic [31:0] seed = 32'h0000F228, r;
    logic sel, rdm, blk;
    logic [7:0] txq[$];
    int miscompares = 0, samples_checked = 0, rxn = 0, n0, it, n;
    logic ok;
    always #25 i_clk = ~i_clk;
    eeprom_link_if eeprom_link_if_i ();
    bus_master_end bus_master_end_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .link(eeprom_link_if_i), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
        .i_wdata(i_wdata), .i_ack_send(i_ack_send), .o_cmd_ready(o_cmd_ready),
        .o_done(o_done), .o_rdata(o_rdata), .o_ack_seen(o_ack_seen));
    eeprom_slave_end eeprom_slave_end_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .link(eeprom_link_if_i), .i_chip_select_bit_a(csa), .i_chip_select_bit_b(csb),
        .i_write_inhibit_input(inh), .i_write_inhibit_driven(drv), .i_busy(i_busy),
        .i_tx_byte(i_tx_byte), .o_tx_load(o_tx_load), .o_rx_byte(o_rx_byte),
        .o_rx_valid(o_rx_valid), .o_start(o_start), .o_stop(o_stop),
        .o_selected(sel), .o_read_mode(rdm), .o_block_bit(blk), .o_standby(o_standby));
    eeprom_link_props eeprom_link_props_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .scl(eeprom_link_if_i.scl), .sda(eeprom_link_if_i.sda),
        .dev_sda_out(eeprom_link_if_i.dev_sda_out),
        .dev_sda_oe_n(eeprom_link_if_i.dev_sda_oe_n),
        .host_scl_out(eeprom_link_if_i.host_scl_out),
        .host_sda_out(eeprom_link_if_i.host_sda_out),
        .o_start(o_start), .o_stop(o_stop));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task test_done();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cmd(input host_cmd_t c, input logic [7:0] d, input logic k);
        @(posedge i_clk);
        i_cmd_valid <= 1'b1;
        i_cmd <= c;
        i_wdata <= d;
        i_ack_send <= k;
        @(posedge i_clk);
        i_cmd_valid <= 1'b0;
        // a byte takes nine bits of eight cycles; a missing done counts as a mismatch
        for (n = 0; n < 100 && o_done !== 1'b1; n++) @(posedge i_clk);
        chk({o_done, o_cmd_ready}, 8'h03);
    endtask
    // byte source for reads, noting each byte taken
    always @(posedge i_clk) begin
        if (o_tx_load === 1'b1) begin
            txq.push_back(i_tx_byte);
            i_tx_byte <= xs();
        end
        if (o_rx_valid === 1'b1) rxn++;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge i_clk);
        i_reset_n <= 1'b1;
        for (it = 0; it < 16; it++) begin
            r = xs();
            csa <= r[0];
            csb <= r[1];
            inh <= r[2];
            drv <= r[3];
            i_busy <= (r[7:5] == 3'h0);
            a = (r[8] || it < 2) ? {4'hA, r[0], r[1], r[10], it[0] ^ r[9]} : r[23:16];
            ok = a[7:4] == 4'hA && a[3] == r[0] && a[2] == r[1] && r[7:5] != 3'h0;
            repeat (6) @(posedge i_clk);
            txq.delete();
            cmd(CMD_START, 8'h00, 1'b0);
            cmd(CMD_WRITE, a, 1'b0);
            chk(o_ack_seen, ok);
            chk(sel, ok);
            if (ok && !a[0]) begin
                n0 = rxn;
                cmd(CMD_WRITE, r[31:24], 1'b0);
                chk(o_ack_seen, 1'b1);
                chk(rxn - n0, !(r[2] && r[3]));
                if (!(r[2] && r[3])) chk(o_rx_byte, r[31:24]);
                // start in mid-write restarts address reception
                cmd(CMD_START, 8'h00, 1'b0);
                cmd(CMD_WRITE, a, 1'b0);
                chk(o_ack_seen, 1'b1);
            end
            if (ok && a[0]) begin
                cmd(CMD_READ, 8'h00, 1'b1);
                chk(o_rdata, txq.pop_front());
                chk({rdm, blk}, {6'h00, 1'b1, a[1]});
                cmd(CMD_READ, 8'h00, 1'b0);
                chk(o_rdata, txq.pop_front());
                cmd(CMD_READ, 8'h00, 1'b0);
                chk(o_rdata, 8'hFF);
            end
            cmd(CMD_STOP, 8'h00, 1'b0);
            repeat (6) @(posedge i_clk);
            chk(o_standby, ok && a[0]);
        end
        test_done();
    end
    // hang guard
    initial begin
        #2000000;
        miscompares++;
        test_done();
    end
endmodule
